//--- dv/dsf_cpu_mdl.sv
// CPU master model: one data-bus transfer at a time.
// Assumes the bench calls acc just after a rising edge.
`timescale 1ns/1ps
module dsf_cpu_mdl (
    // Clock
    input wire logic clk,
    // Request
    output logic cpu_req,
    output logic cpu_we,
    output logic cpu_direct_io,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    output logic [1:0] cpu_bit_op,
    output logic [2:0] cpu_bit_idx,
    // Answer
    input wire logic cpu_ack,
    input wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_req = 1'b0;
        cpu_we = 1'b0;
        cpu_direct_io = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        cpu_bit_op = 2'b00;
        cpu_bit_idx = 3'd0;
    end

    task automatic acc(input logic w, input logic d, input logic [15:0] a, input logic [7:0] wd,
        input logic [1:0] op, input logic [2:0] ix, output logic [7:0] rd, output int lat);
        @(posedge clk);
        #1;
        cpu_req = 1'b1;
        cpu_we = w;
        cpu_direct_io = d;
        cpu_addr = a;
        cpu_wdata = wd;
        cpu_bit_op = op;
        cpu_bit_idx = ix;
        @(posedge clk);
        #1;
        // Released address and data lines do not keep the last value
        cpu_req = 1'b0;
        cpu_addr = ~cpu_addr;
        cpu_wdata = ~cpu_wdata;
        // The taking edge counts as the first cycle
        lat = 1;
        while (cpu_ack !== 1'b1 && lat < 9) begin
            @(posedge clk);
            #1;
            lat++;
        end
        rd = cpu_rdata;
    endtask
endmodule

//--- dv/dsf_data_space_chk.sv
// Checker for answer timing and nonvolatile launch control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module dsf_data_space_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CPU side
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic cpu_direct_io,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [1:0] cpu_bit_op,
    input wire logic cpu_ready,
    input wire logic cpu_ack,
    input wire logic eeprom_map_en,
    input wire logic config_change_guard,
    // Nonvolatile side
    input wire logic nv_launch,
    input wire logic [6:0] nv_opcode,
    input wire logic nonvolatile_busy_flag,
    input wire logic nv_op_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic tk = cpu_req && cpu_ready;
    wire logic pl = tk && cpu_bit_op == 2'b00 && !cpu_direct_io;
    sequence s_wait;
        !cpu_ack && !cpu_ready;
    endsequence
    sequence s_done;
        cpu_ack && cpu_ready;
    endsequence

    AST_IO_ONE: assert property (tk && (cpu_direct_io || cpu_addr < 16'h1000) |=> cpu_ack)
        else $error("io access not answered in one cycle");
    AST_SRAM_RD: assert property (pl && !cpu_we && cpu_addr[15:12] == 4'h2 |=> s_wait ##1 s_done)
        else $error("sram read not answered in two cycles");
    AST_EE_RD: assert property (pl && !cpu_we && eeprom_map_en && cpu_addr[15:12] == 4'h1
        |=> s_wait [*2] ##1 s_done) else $error("eeprom read not answered in three cycles");
    AST_OPCODE: assert property (pl && cpu_we && cpu_addr == 16'h01ca
        |=> nv_opcode == $past(cpu_wdata[6:0])) else $error("opcode not loaded");
    AST_LAUNCH: assert property (pl && cpu_we && cpu_addr == 16'h01cb && cpu_wdata[0]
        && config_change_guard && !nonvolatile_busy_flag |=> nv_launch && nonvolatile_busy_flag)
        else $error("launch missing");
    AST_GUARD: assert property ($rose(nv_launch) |-> $past(config_change_guard && cpu_req))
        else $error("launch without guard");
    AST_STROBE: assert property (nv_launch |=> !nv_launch)
        else $error("launch longer than one cycle");
    AST_BUSY: assert property (nonvolatile_busy_flag && !nv_op_done |=> nonvolatile_busy_flag)
        else $error("busy dropped early");
    AST_BUSY_END: assert property (nonvolatile_busy_flag && nv_op_done |=> !nonvolatile_busy_flag)
        else $error("busy not cleared");
endmodule

bind dsf_data_space dsf_data_space_chk u_chk (.*);

//--- dv/dsf_data_space_tb.sv
// Bench for the data-space front end: regions, bit access, lock,
// identity and nonvolatile registers. Plays peripherals and engine itself.
`timescale 1ns/1ps
module dsf_data_space_tb
    import dsf_pkg::*;
;
    localparam logic [23:0] ID_V = 24'h5a_c3e1; // Arbitrary value
    localparam logic [7:0] REV_V = 8'h2b; // Arbitrary value
    logic clk, rst, eeprom_map_en, config_change_guard, nv_op_done, nv_result_valid;
    logic cpu_req, cpu_we, cpu_direct_io, cpu_ready, cpu_ack, io_rd, io_wr, nv_launch;
    logic nonvolatile_busy_flag;
    logic [1:0] cpu_bit_op;
    logic [2:0] cpu_bit_idx;
    logic [6:0] nv_opcode;
    logic [7:0] cpu_wdata, cpu_rdata, io_rdata, io_wdata;
    logic [11:0] io_addr;
    logic [15:0] cpu_addr;
    logic [23:0] nv_location, nv_value, nv_result;
    int failures = 0;
    int total_checks = 0;
    int launches = 0;
    int io_writes = 0;
    int io_reads = 0;
    logic [11:0] wr_addr_seen = 12'h000;
    logic [7:0] wr_data_seen = 8'h00;

    dsf_data_space #(.DEVICE_ID(ID_V), .REVISION(REV_V)) dut (.*);
    dsf_cpu_mdl cpu (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nv_launch === 1'b1) launches++;
        if (io_wr === 1'b1) io_writes++;
        if (io_rd === 1'b1) io_reads++;
        if (io_wr === 1'b1) wr_addr_seen = io_addr;
        if (io_wr === 1'b1) wr_data_seen = io_wdata;
    end

    task automatic end_sim;
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xa(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [1:0] op,
        input logic [2:0] ix, input logic [7:0] e, input int el);
        logic [7:0] rd;
        int lat;
        cpu.acc(w, 1'b0, a, d, op, ix, rd, lat);
        chk("latency", 24'(el), 24'(lat));
        if (!w) chk("read data", {16'h0000, e}, {16'h0000, rd});
        // Lost answer already counted, end the run
        if (lat > 8) end_sim();
    endtask
    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        xa(1'b1, a, d, 2'b00, 3'd0, 8'h00, 1);
    endtask
    task automatic xr(input logic [15:0] a, input logic [7:0] e, input int el);
        xa(1'b0, a, 8'h00, 2'b00, 3'd0, e, el);
    endtask

    task automatic t_mem;
        xw(16'h2005, 8'ha5);
        xw(16'h2fff, 8'h5a);
        xr(16'h2005, 8'ha5, 2);
        xr(16'h2fff, 8'h5a, 2);
        eeprom_map_en = 1'b1;
        xw(16'h1003, 8'h3c);
        xr(16'h1003, 8'h3c, 3);
        eeprom_map_en = 1'b0;
        xr(16'h1003, 8'h00, 1);
    endtask
    task automatic t_bits;
        int n;
        int m;
        logic [7:0] rd;
        int lat;
        xw(16'h0002, 8'h00);
        xa(1'b0, 16'h0002, 8'h00, DSF_BIT_SET, 3'd3, 8'h00, 1);
        xa(1'b0, 16'h0002, 8'h00, DSF_BIT_TEST, 3'd3, 8'h01, 1);
        xr(16'h0002, 8'h08, 1);
        xa(1'b0, 16'h0002, 8'h00, DSF_BIT_CLR, 3'd3, 8'h00, 1);
        xr(16'h0002, 8'h00, 1);
        xw(16'h0001, 8'h77);
        cpu.acc(1'b0, 1'b1, 16'hff01, 8'h00, 2'b00, 3'd0, rd, lat);
        chk("direct read", 24'h00_0077, {16'h0000, rd});
        chk("direct latency", 24'h00_0001, 24'(lat));
        if (lat > 8) end_sim();
        n = io_writes;
        m = io_reads;
        xa(1'b0, 16'h0020, 8'h00, DSF_BIT_SET, 3'd0, 8'h00, 1);
        chk("bit op above range", 24'(n), 24'(io_writes));
        chk("bit op above range read", 24'(m), 24'(io_reads));
        xa(1'b0, 16'h0010, 8'h00, DSF_BIT_SET, 3'd0, 8'h00, 1);
        chk("rmw address", 24'h00_0010, {12'h000, wr_addr_seen});
        chk("rmw data", 24'h00_006f, {16'h0000, wr_data_seen});
    endtask
    task automatic t_lock;
        int n;
        int m;
        for (int i = 0; i < 3; i++) begin
            xr({4'h0, ID_NVM_LOCATION_LOW} + 16'(i), ID_V[8*i +: 8], 1);
        end
        xr({4'h0, REV_ADDR}, REV_V, 1);
        xw({4'h0, ID_NVM_LOCATION_LOW}, ~ID_V[7:0]);
        xr({4'h0, ID_NVM_LOCATION_LOW}, ID_V[7:0], 1);
        xw(16'h0070, 8'h07);
        xr(16'h0070, 8'h00, 1);
        n = io_writes;
        xw(16'h0041, 8'h11);
        chk("open write", 24'(n + 1), 24'(io_writes));
        chk("open write address", 24'h00_0041, {12'h000, wr_addr_seen});
        chk("open write data", 24'h00_0011, {16'h0000, wr_data_seen});
        config_change_guard = 1'b1;
        xw(16'h0070, 8'h01);
        config_change_guard = 1'b0;
        xr(16'h0070, 8'h01, 1);
        n = io_writes;
        xw(16'h0041, 8'h22);
        xw(16'h0185, 8'h33);
        chk("locked write", 24'(n + 1), 24'(io_writes));
        m = io_reads;
        xr(16'h0185, 8'h6e, 1);
        chk("peripheral read strobe", 24'(m + 1), 24'(io_reads));
    endtask
    task automatic t_nv;
        int n;
        for (int i = 0; i < 3; i++) begin
            xw(16'h01c0 + 16'(i), 8'(8'h11 * (i + 1)));
            xw(16'h01c4 + 16'(i), 8'(8'ha0 + i));
        end
        chk("location", 24'h33_2211, nv_location);
        chk("value", 24'ha2_a1a0, nv_value);
        xw(16'h01ca, 8'h45);
        chk("opcode", 24'h00_0045, {17'h0_0000, nv_opcode});
        n = launches;
        xw(16'h01cb, 8'h01);
        chk("open launch", 24'h00_0000, {23'h00_0000, nv_launch});
        config_change_guard = 1'b1;
        xw(16'h01cb, 8'h01);
        chk("launch", 24'h00_0001, {23'h00_0000, nv_launch});
        xw(16'h01cb, 8'h01);
        config_change_guard = 1'b0;
        chk("busy launch", 24'h00_0000, {23'h00_0000, nv_launch});
        chk("launch count", 24'(n + 1), 24'(launches));
        xr(16'h01cb, 8'h00, 1);
        xr(16'h01cf, 8'h80, 1);
        nv_result = 24'h0f_e1d2;
        nv_result_valid = 1'b1;
        nv_op_done = 1'b1;
        @(posedge clk);
        #1;
        nv_result_valid = 1'b0;
        nv_op_done = 1'b0;
        xr(16'h01cf, 8'h00, 1);
        xr(16'h01c6, 8'h0f, 1);
    endtask

    initial begin
        rst = 1'b1;
        eeprom_map_en = 1'b0;
        config_change_guard = 1'b0;
        io_rdata = 8'h6e;
        nv_op_done = 1'b0;
        nv_result_valid = 1'b0;
        nv_result = 24'h00_0000;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("location reset", 24'h00_00ff, nv_location);
        t_mem();
        t_bits();
        t_lock();
        t_nv();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule

//--- logic/dsf_data_space.sv
// Data-space front end: region decode, bit-accessible I/O bytes, I/O lock,
// identification bytes and nonvolatile controller registers.
// Assumes a CPU master on the same clock and peripherals answering in-cycle.
`timescale 1ns/1ps
module dsf_data_space
    import dsf_pkg::*;
#(
    parameter logic [23:0] DEVICE_ID = 24'h12_3456, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CPU request
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic cpu_direct_io,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [1:0] cpu_bit_op,
    input wire logic [2:0] cpu_bit_idx,
    // CPU answer
    output logic cpu_ready,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata,
    // System control
    input wire logic eeprom_map_en,
    input wire logic config_change_guard,
    // Peripheral I/O bus
    output logic io_rd,
    output logic io_wr,
    output logic [11:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // Nonvolatile engine
    output logic nv_launch,
    output logic [6:0] nv_opcode,
    output logic [23:0] nv_location,
    output logic [23:0] nv_value,
    output logic nonvolatile_busy_flag,
    input wire logic nv_op_done,
    input wire logic nv_result_valid,
    input wire logic [23:0] nv_result
);

    function automatic dsf_region_t region_of(input logic [15:0] a, input logic map_en);
        if (a < EE_BASE) begin
            return DSF_REG_IO;
        end else if (a < SRAM_BASE) begin
            return map_en ? DSF_REG_EE : DSF_REG_NONE;
        end else if (a <= SRAM_END) begin
            return DSF_REG_SRAM;
        end
        return DSF_REG_NONE;
    endfunction

    function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] bit_apply(input logic [7:0] v, input logic [1:0] op, input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h01 << idx;
        return (op == DSF_BIT_SET) ? (v | m) : (v & ~m);
    endfunction

    // Owned register state
    logic [7:0] gp_r [0:3];
    logic [7:0] gp_nxt [0:3];
    logic [2:0] lock_r, lock_nxt;
    logic [23:0] loc_r, loc_nxt;
    logic [23:0] val_r, val_nxt;
    logic [6:0] opc_r, opc_nxt;
    logic busy_r, busy_nxt;
    logic launch_r, launch_nxt;

    // Request pipeline state
    logic ack_r, ack_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic sram_p_r, sram_p_nxt;
    logic ee_p1_r, ee_p1_nxt;
    logic ee_p2_r, ee_p2_nxt;

    // Request decode
    logic take;
    logic [15:0] eff_addr;
    logic [11:0] ia;
    dsf_region_t reg_sel;
    dsf_bitop_t bop;
    logic bit_ok, is_bit_wr, is_write, own_hit, locked;
    logic [7:0] own_val, cur_val, wr_val;
    logic [3:0] nv_ofs;
    logic sram_en, ee_en;
    logic [7:0] sram_q, ee_q;

    assign cpu_ready = !(sram_p_r || ee_p1_r || ee_p2_r);
    assign take = cpu_req && cpu_ready;
    assign eff_addr = cpu_direct_io ? {10'h000, cpu_addr[5:0] & DIRECT_IO_MASK} : cpu_addr;
    assign ia = eff_addr[IO_AW-1:0];
    assign reg_sel = region_of(eff_addr, eeprom_map_en);
    assign bop = dsf_bitop_t'(cpu_bit_op);
    assign bit_ok = (bop != DSF_BIT_NONE) && (reg_sel == DSF_REG_IO) && (ia <= IO_BIT_TOP);
    assign is_bit_wr = bit_ok && (bop != DSF_BIT_TEST);
    assign is_write = (bop == DSF_BIT_NONE) ? cpu_we : is_bit_wr;
    assign nv_ofs = ia[3:0];

    always_comb begin
        own_hit = 1'b1;
        own_val = BYTE_ZERO;
        if (ia <= GP_TOP) begin
            own_val = gp_r[ia[1:0]];
        end else if (ia == ID_NVM_LOCATION_LOW) begin
            own_val = DEVICE_ID[7:0];
        end else if (ia == ID_NVM_LOCATION_MID) begin
            own_val = DEVICE_ID[15:8];
        end else if (ia == ID_NVM_LOCATION_HIGH) begin
            own_val = DEVICE_ID[23:16];
        end else if (ia == REV_ADDR) begin
            own_val = REVISION;
        end else if (ia == LOCK_ADDR) begin
            own_val = {5'h00, lock_r};
        end else if ((ia & NV_MASK) == NV_BASE) begin
            unique case (nv_ofs)
                OFS_LOC_LOW: own_val = loc_r[7:0];
                OFS_LOC_MID: own_val = loc_r[15:8];
                OFS_LOC_HIGH: own_val = loc_r[23:16];
                OFS_VAL_LOW: own_val = val_r[7:0];
                OFS_VAL_MID: own_val = val_r[15:8];
                OFS_VAL_HIGH: own_val = val_r[23:16];
                OFS_OPCODE: own_val = {1'b0, opc_r};
                OFS_STATUS: own_val = {busy_r, 7'h00};
                default: own_val = BYTE_ZERO;
            endcase
        end else begin
            own_hit = 1'b0;
        end
    end

    assign locked = (lock_r[LOCK_CLK] && in_range(ia, CLK_LO, CLK_HI))
        || (lock_r[LOCK_EVT] && in_range(ia, EVT_LO, EVT_HI))
        || (lock_r[LOCK_WEX] && in_range(ia, WEX_LO, WEX_HI));
    assign cur_val = own_hit ? own_val : io_rdata;
    assign wr_val = is_bit_wr ? bit_apply(cur_val, cpu_bit_op, cpu_bit_idx) : cpu_wdata;

    // Peripheral bus, same-cycle strobes
    assign io_addr = ia;
    assign io_wdata = wr_val;
    // Refused bit ops must not strobe a peripheral read
    assign io_rd = take && (reg_sel == DSF_REG_IO) && !own_hit && ((bop == DSF_BIT_NONE) ? !cpu_we : bit_ok);
    assign io_wr = take && (reg_sel == DSF_REG_IO) && !own_hit && is_write && !locked;

    // Memories
    assign sram_en = take && (reg_sel == DSF_REG_SRAM) && (bop == DSF_BIT_NONE);
    assign ee_en = take && (reg_sel == DSF_REG_EE) && (bop == DSF_BIT_NONE);

    dsf_mem #(.AW(SRAM_AW)) u_sram (
        .clk(clk),
        .en(sram_en),
        .we(cpu_we),
        .addr(eff_addr[SRAM_AW-1:0]),
        .wdata(cpu_wdata),
        .rdata(sram_q)
    );

    dsf_mem #(.AW(EE_AW)) u_eeprom (
        .clk(clk),
        .en(ee_en),
        .we(cpu_we),
        .addr(eff_addr[EE_AW-1:0]),
        .wdata(cpu_wdata),
        .rdata(ee_q)
    );

    // Request pipeline next state
    always_comb begin
        ack_nxt = 1'b0;
        rdata_nxt = rdata_r;
        sram_p_nxt = 1'b0;
        ee_p1_nxt = 1'b0;
        ee_p2_nxt = ee_p1_r;
        if (sram_p_r) begin
            ack_nxt = 1'b1;
            rdata_nxt = sram_q;
        end else if (ee_p2_r) begin
            ack_nxt = 1'b1;
            rdata_nxt = ee_q;
        end else if (take) begin
            rdata_nxt = BYTE_ZERO;
            unique case (reg_sel)
                DSF_REG_IO: begin
                    ack_nxt = 1'b1;
                    if (bop == DSF_BIT_TEST && bit_ok) begin
                        rdata_nxt = {7'h00, cur_val[cpu_bit_idx]};
                    end else if (!is_write && bop == DSF_BIT_NONE) begin
                        rdata_nxt = cur_val;
                    end
                end
                DSF_REG_SRAM: begin
                    ack_nxt = cpu_we || (bop != DSF_BIT_NONE);
                    sram_p_nxt = !cpu_we && (bop == DSF_BIT_NONE);
                end
                DSF_REG_EE: begin
                    ack_nxt = cpu_we || (bop != DSF_BIT_NONE);
                    ee_p1_nxt = !cpu_we && (bop == DSF_BIT_NONE);
                end
                DSF_REG_NONE: begin
                    ack_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= BYTE_ZERO;
            sram_p_r <= 1'b0;
            ee_p1_r <= 1'b0;
            ee_p2_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            sram_p_r <= sram_p_nxt;
            ee_p1_r <= ee_p1_nxt;
            ee_p2_r <= ee_p2_nxt;
        end
    end

    assign cpu_ack = ack_r;
    assign cpu_rdata = rdata_r;

    // Owned register next state
    logic wr_own;
    assign wr_own = take && (reg_sel == DSF_REG_IO) && own_hit && is_write;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gp_nxt[i] = gp_r[i];
        end
        lock_nxt = lock_r;
        loc_nxt = loc_r;
        val_nxt = val_r;
        opc_nxt = opc_r;
        launch_nxt = 1'b0;
        busy_nxt = busy_r;
        if (nv_op_done) begin
            busy_nxt = 1'b0;
        end
        if (wr_own) begin
            if (ia <= GP_TOP) begin
                gp_nxt[ia[1:0]] = wr_val;
            end else if (ia == LOCK_ADDR) begin
                if (config_change_guard) begin
                    lock_nxt = wr_val[2:0];
                end
            end else if ((ia & NV_MASK) == NV_BASE) begin
                unique case (nv_ofs)
                    OFS_LOC_LOW: loc_nxt[7:0] = wr_val;
                    OFS_LOC_MID: loc_nxt[15:8] = wr_val;
                    OFS_LOC_HIGH: loc_nxt[23:16] = wr_val;
                    OFS_VAL_LOW: val_nxt[7:0] = wr_val;
                    OFS_VAL_MID: val_nxt[15:8] = wr_val;
                    OFS_VAL_HIGH: val_nxt[23:16] = wr_val;
                    OFS_OPCODE: opc_nxt = wr_val[6:0] & OPCODE_MASK;
                    OFS_LAUNCH: begin
                        if (wr_val[TRIGGER_BIT] && config_change_guard && !busy_r) begin
                            launch_nxt = 1'b1;
                            busy_nxt = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (nv_result_valid) begin
            val_nxt = nv_result;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                gp_r[i] <= BYTE_ZERO;
            end
            lock_r <= 3'h0;
            loc_r <= {BYTE_ZERO, BYTE_ZERO, LOC_LOW_RST};
            val_r <= 24'h00_0000;
            opc_r <= 7'h00;
            busy_r <= 1'b0;
            launch_r <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                gp_r[i] <= gp_nxt[i];
            end
            lock_r <= lock_nxt;
            loc_r <= loc_nxt;
            val_r <= val_nxt;
            opc_r <= opc_nxt;
            busy_r <= busy_nxt;
            launch_r <= launch_nxt;
        end
    end

    assign nv_launch = launch_r;
    assign nv_opcode = opc_r;
    assign nv_location = loc_r;
    assign nv_value = val_r;
    assign nonvolatile_busy_flag = busy_r;

endmodule

//--- logic/dsf_mem.sv
// Single-port byte memory with registered read data.
// Assumes one clock; read data update only on an enabled read.
`timescale 1ns/1ps
module dsf_mem #(
    parameter int AW = 10
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    // Read data
    output logic [7:0] rdata
);

    logic [7:0] mem [0:(1 << AW)-1];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end

endmodule

//--- pkg/dsf_pkg.sv
// Package for the data-space front end: address map, register offsets,
// reset values and access encodings shared by the design files.
// Assumes one system clock and a CPU core as the only bus master.
package dsf_pkg;

    // Linear data space
    localparam int ADDR_W = 16;
    localparam int IO_AW = 12;
    localparam int SRAM_AW = 12;
    localparam int EE_AW = 10;
    localparam logic [15:0] IO_BASE = 16'h0000;
    localparam logic [15:0] EE_BASE = 16'h1000;
    localparam logic [15:0] SRAM_BASE = 16'h2000;
    localparam logic [15:0] SRAM_END = 16'h2FFF;

    // Direct I/O reach and bit-access reach
    localparam logic [5:0] DIRECT_IO_MASK = 6'h3F;
    localparam logic [11:0] IO_BIT_TOP = 12'h01F;
    localparam logic [11:0] GP_TOP = 12'h003;

    // Identification and revision bytes
    localparam logic [11:0] ID_NVM_LOCATION_LOW = 12'h090;
    localparam logic [11:0] ID_NVM_LOCATION_MID = 12'h091;
    localparam logic [11:0] ID_NVM_LOCATION_HIGH = 12'h092;
    localparam logic [11:0] REV_ADDR = 12'h093;

    // Protection lock register and its bits
    localparam logic [11:0] LOCK_ADDR = 12'h070;
    localparam int LOCK_CLK = 0;
    localparam int LOCK_EVT = 1;
    localparam int LOCK_WEX = 2;

    // Protected peripheral windows
    localparam logic [11:0] CLK_LO = 12'h040;
    localparam logic [11:0] CLK_HI = 12'h04F;
    localparam logic [11:0] EVT_LO = 12'h180;
    localparam logic [11:0] EVT_HI = 12'h1BF;
    localparam logic [11:0] WEX_LO = 12'h880;
    localparam logic [11:0] WEX_HI = 12'h8BF;

    // Nonvolatile controller block
    localparam logic [11:0] NV_BASE = 12'h1C0;
    localparam logic [11:0] NV_MASK = 12'hFF0;
    localparam logic [3:0] OFS_LOC_LOW = 4'h0;
    localparam logic [3:0] OFS_LOC_MID = 4'h1;
    localparam logic [3:0] OFS_LOC_HIGH = 4'h2;
    localparam logic [3:0] OFS_VAL_LOW = 4'h4;
    localparam logic [3:0] OFS_VAL_MID = 4'h5;
    localparam logic [3:0] OFS_VAL_HIGH = 4'h6;
    localparam logic [3:0] OFS_OPCODE = 4'hA;
    localparam logic [3:0] OFS_LAUNCH = 4'hB;
    localparam logic [3:0] OFS_STATUS = 4'hF;
    localparam int TRIGGER_BIT = 0;
    localparam int BUSY_BIT = 7;
    localparam logic [7:0] LOC_LOW_RST = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] OPCODE_MASK = 7'h7F;

    // Data-space regions
    typedef enum logic [1:0] {
        DSF_REG_IO,
        DSF_REG_EE,
        DSF_REG_SRAM,
        DSF_REG_NONE
    } dsf_region_t;

    // Single-bit operations
    typedef enum logic [1:0] {
        DSF_BIT_NONE,
        DSF_BIT_SET,
        DSF_BIT_CLR,
        DSF_BIT_TEST
    } dsf_bitop_t;

endpackage
